// file: adccfg_regs.sv
// Purpose: configuration and channel-setup register bank with decoding
// Assumes: one master clock; words come from the serial command port
// Notes:   every output is registered; config flags show one cycle later, setup decodes two
//
// Functional notes
// - power-down enters standby or sleep per kind
// - reset command bit starts internal reset cycle
// - reset-done flag reads one, cleared on read
// - input short shorts all channel input pairs
// - guard drive takes first latch pin
// - reference range bit picks sampling capacitor
// - latch source picks setup or configuration bits
// - configuration latch field drives pins on command
// - calibration pointer picks channel or setup index
// - rate scale multiplies word rates by 5/6
// - word rates scale with master clock
// - four setup registers, two setups each
// - command 05 writes one setup register
// - setup field layout from the top
// - channel pick selects physical input 1-4
// - every setup is independent of others
// - rate code selects word rate table
// - settle delay 1280 or 1536 cycles
// - calibration index selects register pair 1-4
`timescale 1ns/100ps
`default_nettype none
module adccfg_regs
  import adccfg_pkg::*;
(
  input  wire logic        clk_in,          // master clock, 4.9152 MHz
  input  wire logic        reset_in,        // sync reset, active high
  input  wire logic        cmd_valid_in,    // command with its word
  input  wire logic [7:0]  cmd_byte_in,     // command byte
  input  wire logic [31:0] cmd_data_in,     // write word
  input  wire logic [2:0]  setup_sel_in,    // setup chosen for conversion
  input  wire logic        conv_req_in,     // conversion start request
  output logic             rd_valid_out,    // read word valid pulse
  output logic [31:0]      rd_data_out,     // read word
  output logic             power_down_out,  // power-save active
  output logic             sleep_out,       // sleep, oscillator off
  output logic             osc_run_out,     // oscillator enable
  output logic             sys_reset_out,   // reset cycle pulse
  output logic             reset_done_out,  // reset-done flag
  output logic             input_short_out, // inputs shorted
  output logic             guard_drive_out, // first pin carries guard
  output logic             ref_range_out,   // small reference range
  output logic             latch_a0_out,    // first latch pin
  output logic             latch_a1_out,    // second latch pin
  output logic [1:0]       channel_out,     // physical channel
  output logic [2:0]       gain_out,        // amplifier gain code
  output logic [19:0]      word_period_out, // clocks per output word
  output logic             rate_valid_out,  // rate code is defined
  output logic             polarity_out,    // polarity select
  output logic             open_detect_out, // open detect source on
  output logic [1:0]       cal_index_out,   // offset/gain pair index
  output logic             settle_busy_out, // settle wait running
  output logic             conv_go_out      // conversion start pulse
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // pick one setup out of the bank; setup 0 is the upper half
  function automatic logic [15:0] get_setup(input logic [127:0] bank,
                                            input logic [2:0]   sel);
    logic [31:0] word;
    word = bank[32*sel[2:1] +: 32];
    get_setup = sel[0] ? word[15:0] : word[31:16];
  endfunction

  // clocks per word; in clocks, so the rate follows the clock itself
  function automatic logic [20:0] rate_period(input logic [3:0] code,
                                              input logic       scl);
    logic [19:0] base;
    base = 20'h0;
    case (code)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4: base = WORD_CYC_BASE << code[2:0];
      4'h8, 4'h9, 4'hA, 4'hB, 4'hC: base = WORD_CYC_FAST << code[2:0];
      default: base = 20'h0;
    endcase
    // 5/6 rate means 6/5 period; all table values divide by five
    if (scl) begin
      base = base + base / 20'd5;
    end
    rate_period = {(base != 20'h0), base};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0]   cfg, next_cfg;
  logic [127:0]  channel_setup, next_csr;
  logic          rv, next_rv;
  adccfg_state_e state, next_state;
  logic [10:0]   cnt, next_cnt;
  logic          next_rd_valid, next_sys_reset, next_go;
  logic [31:0]   next_rd_data;
  logic          next_a0, next_a1;
  logic [15:0]   su;
  logic [20:0]   per;
  logic          cfg_wr, cfg_rd, csr_wr, csr_rd;
  logic [1:0]    idx;

  // command decode
  assign cfg_wr = cmd_valid_in && (cmd_byte_in == CMD_CFG_WR);
  assign cfg_rd = cmd_valid_in && (cmd_byte_in == CMD_CFG_RD);
  assign csr_wr = cmd_valid_in &&
                  ((cmd_byte_in & CMD_IDX_MASK) == CMD_CSR_WR);
  assign csr_rd = cmd_valid_in &&
                  ((cmd_byte_in & CMD_IDX_MASK) == CMD_CSR_RD);
  assign idx    = cmd_byte_in[CMD_IDX_LSB +: 2];
  // each setup decodes alone from its own half word
  assign su     = get_setup(channel_setup, setup_sel_in);
  assign per    = rate_period(su[SU_RATE_LSB +: 4], cfg[CFG_FRS]);

  // ----------------------------------------------------------------
  // register file next values
  // ----------------------------------------------------------------
  always_comb begin
    next_cfg       = cfg;
    next_csr       = channel_setup;
    next_rv        = rv;
    next_rd_valid  = 1'b0;
    next_rd_data   = rd_data_out;
    next_sys_reset = 1'b0;
    if (cfg_wr) begin
      if (cmd_data_in[CFG_RS]) begin
        // reset cycle: only the reset bit survives the write
        next_cfg         = CFG_RESET;
        next_cfg[CFG_RS] = 1'b1;
        next_csr         = {4{CSR_RESET}};
        next_rv          = 1'b1;
        next_sys_reset   = 1'b1;
      end else begin
        // host should send zeros; storage drops them anyway
        next_cfg = cmd_data_in & CFG_WR_MASK;
      end
    end
    if (csr_wr) begin
      // whole word, both setups at once
      next_csr[32*idx +: 32] = cmd_data_in;
    end
    if (cfg_rd) begin
      next_rd_valid        = 1'b1;
      next_rd_data         = cfg;
      next_rd_data[CFG_RV] = rv;
      next_rv              = 1'b0;
    end
    if (csr_rd) begin
      next_rd_valid = 1'b1;
      next_rd_data  = channel_setup[32*idx +: 32];
    end
  end

  // ----------------------------------------------------------------
  // latch pins, refreshed when any command executes
  // ----------------------------------------------------------------
  always_comb begin
    next_a0 = latch_a0_out;
    next_a1 = latch_a1_out;
    if (cmd_valid_in) begin
      if (next_cfg[CFG_OLS]) begin
        next_a1 = next_cfg[CFG_LAT_LO];
        next_a0 = next_cfg[CFG_LAT_HI];
      end else begin
        next_a1 = su[SU_LAT_LSB];
        next_a0 = su[SU_LAT_LSB + 1];
      end
      // guard output owns the first pin; source select is moot there
      if (next_cfg[CFG_GB]) begin
        next_a0 = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // settle delay before a conversion starts
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_go    = 1'b0;
    case (state)
      ADCCFG_IDLE: begin
        // requests ignored while powered down; a settle wait already running still ends in a start
        if (conv_req_in && !cfg[CFG_PDW]) begin
          if (su[SU_DT]) begin
            next_state = ADCCFG_WAIT;
            next_cnt = cfg[CFG_FRS] ? SETTLE_CYC_SCL : SETTLE_CYC;
          end else begin
            next_go = 1'b1;
          end
        end
      end
      ADCCFG_WAIT: begin
        next_cnt = cnt - 11'd1;
        if (cnt == 11'd1) begin
          next_go    = 1'b1;
          next_state = ADCCFG_IDLE;
        end
      end
      default: begin
        next_state = ADCCFG_IDLE;
        next_cnt   = 11'd0;
      end
    endcase
    // a reset cycle abandons any pending start
    if (next_sys_reset) begin
      next_state = ADCCFG_IDLE;
      next_go    = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg             <= CFG_RESET;
      channel_setup             <= {4{CSR_RESET}};
      rv              <= 1'b0;
      state           <= ADCCFG_IDLE;
      cnt             <= 11'd0;
      rd_valid_out    <= 1'b0;
      rd_data_out     <= 32'h0000_0000;
      sys_reset_out   <= 1'b0;
      conv_go_out     <= 1'b0;
      latch_a0_out    <= 1'b0;
      latch_a1_out    <= 1'b0;
      power_down_out  <= 1'b0;
      sleep_out       <= 1'b0;
      osc_run_out     <= 1'b1;
      reset_done_out  <= 1'b0;
      input_short_out <= 1'b0;
      guard_drive_out <= 1'b0;
      ref_range_out   <= 1'b0;
      settle_busy_out <= 1'b0;
      channel_out     <= 2'h0;
      gain_out        <= 3'h0;
      word_period_out <= 20'h0;
      rate_valid_out  <= 1'b0;
      polarity_out    <= 1'b0;
      open_detect_out <= 1'b0;
      cal_index_out   <= 2'h0;
    end else begin
      cfg             <= next_cfg;
      channel_setup             <= next_csr;
      rv              <= next_rv;
      state           <= next_state;
      cnt             <= next_cnt;
      rd_valid_out    <= next_rd_valid;
      rd_data_out     <= next_rd_data;
      sys_reset_out   <= next_sys_reset;
      conv_go_out     <= next_go;
      latch_a0_out    <= next_a0;
      latch_a1_out    <= next_a1;
      // standby keeps the oscillator, sleep stops it
      power_down_out  <= next_cfg[CFG_PDW];
      sleep_out       <= next_cfg[CFG_PDW] && next_cfg[CFG_PSS];
      osc_run_out     <= !(next_cfg[CFG_PDW] && next_cfg[CFG_PSS]);
      reset_done_out  <= next_rv;
      input_short_out <= next_cfg[CFG_IS];
      guard_drive_out <= next_cfg[CFG_GB];
      ref_range_out   <= next_cfg[CFG_VRS];
      settle_busy_out <= (next_state == ADCCFG_WAIT);
      // selected setup, decoded per field
      channel_out     <= su[SU_CH_LSB +: 2];
      gain_out        <= su[SU_GAIN_LSB +: 3];
      word_period_out <= per[19:0];
      rate_valid_out  <= per[20];
      polarity_out    <= su[SU_POL];
      open_detect_out <= su[SU_OCD];
      cal_index_out   <= cfg[CFG_OGS] ? su[SU_OG_LSB +: 2]
                                      : su[SU_CH_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  chk_power_mode_set: assert property (
    cfg_wr && !cmd_data_in[CFG_RS] |=>
      power_down_out == $past(cmd_data_in[CFG_PDW]) &&
      osc_run_out == !$past(cmd_data_in[CFG_PDW] && cmd_data_in[CFG_PSS]))
    else $error("power mode does not follow write");

  chk_reset_cycle_run: assert property (
    cfg_wr && cmd_data_in[CFG_RS] |=>
      sys_reset_out && reset_done_out && !power_down_out &&
      !input_short_out ##1 !sys_reset_out)
    else $error("reset cycle wrong");

  chk_reset_flag_read: assert property (
    cfg_rd |=> rd_valid_out && !reset_done_out &&
      rd_data_out[CFG_RV] == $past(reset_done_out))
    else $error("reset flag read or clear wrong");

  chk_short_follow: assert property (
    cfg_wr && !cmd_data_in[CFG_RS] |=>
      input_short_out == $past(cmd_data_in[CFG_IS]))
    else $error("input short not applied");

  chk_guard_pin_free: assert property (
    guard_drive_out |-> !latch_a0_out)
    else $error("first latch pin driven under guard");

  chk_latch_cfg_src: assert property (
    cfg_wr && !cmd_data_in[CFG_RS] && cmd_data_in[CFG_OLS] &&
    !cmd_data_in[CFG_GB] |=>
      latch_a1_out == $past(cmd_data_in[CFG_LAT_LO]) &&
      latch_a0_out == $past(cmd_data_in[CFG_LAT_HI]))
    else $error("latch pins ignore configuration field");

  chk_settle_load: assert property (
    state == ADCCFG_IDLE && conv_req_in && !cfg[CFG_PDW] && su[SU_DT] &&
    !next_sys_reset |=> settle_busy_out && !conv_go_out &&
      cnt == ($past(cfg[CFG_FRS]) ? SETTLE_CYC_SCL : SETTLE_CYC))
    else $error("settle delay loaded wrong");

  chk_settle_end: assert property (
    state == ADCCFG_WAIT && cnt == 11'd1 && !next_sys_reset |=>
      conv_go_out && !settle_busy_out)
    else $error("conversion start missing after settle");

  chk_csr_readback: assert property (
    csr_wr ##1 (csr_rd && idx == $past(idx) && !cfg_wr) |=>
      rd_data_out == $past(cmd_data_in, 2))
    else $error("setup register readback mismatch");

  cov_reset_cycle: cover property (
    cfg_wr && cmd_data_in[CFG_RS] ##[1:20] cfg_rd);
  cov_settle_done: cover property (
    settle_busy_out ##1 conv_go_out);
  cov_scaled_rate: cover property (
    cfg[CFG_FRS] && rate_valid_out && conv_go_out);
endmodule
`default_nettype wire

// file: adccfg_pkg.sv
// Purpose: constants for the converter configuration and setup bank
// Assumes: register words arrive already deserialised, 32 bits wide
// Notes:   command codes other than the setup write are local choices
package adccfg_pkg;
  // ----------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CFG_WR   = 8'h03;
  localparam logic [7:0] CMD_CFG_RD   = 8'h0B;
  localparam logic [7:0] CMD_CSR_WR   = 8'h05; // index in bits 5:4
  localparam logic [7:0] CMD_CSR_RD   = 8'h0D; // index in bits 5:4
  localparam logic [7:0] CMD_IDX_MASK = 8'hCF;
  localparam int         CMD_IDX_LSB  = 4;
  // ----------------------------------------------------------------
  // configuration register fields
  // ----------------------------------------------------------------
  localparam int CFG_PSS    = 31; // power_save_kind
  localparam int CFG_PDW    = 30; // power_down_req
  localparam int CFG_RS     = 29; // system_reset_cmd
  localparam int CFG_RV     = 28; // reset_done_flag
  localparam int CFG_IS     = 27; // input_short_en
  localparam int CFG_GB     = 26; // guard_drive_en
  localparam int CFG_VRS    = 25; // ref_range_sel
  localparam int CFG_LAT_HI = 24; // latch_outputs
  localparam int CFG_LAT_LO = 23;
  localparam int CFG_OLS    = 22; // latch_source_sel
  localparam int CFG_OGS    = 20; // cal_pointer_en
  localparam int CFG_FRS    = 19; // rate_scale_sel
  localparam logic [31:0] CFG_WR_MASK = 32'hEFD8_0000;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
  localparam logic [31:0] CSR_RESET   = 32'h0000_0000;
  // ----------------------------------------------------------------
  // setup fields (within one 16-bit setup)
  // ----------------------------------------------------------------
  localparam int SU_CH_LSB   = 14; // channel_pick, 2 bits
  localparam int SU_GAIN_LSB = 11; // amp_gain_code, 3 bits
  localparam int SU_RATE_LSB = 7;  // rate_code, 4 bits
  localparam int SU_POL      = 6;  // polarity_sel
  localparam int SU_LAT_LSB  = 4;  // setup_latch_bits, 2 bits
  localparam int SU_DT       = 3;  // settle_delay_en
  localparam int SU_OCD      = 2;  // open_detect_src
  localparam int SU_OG_LSB   = 0;  // cal_set_index, 2 bits
  // ----------------------------------------------------------------
  // timing, in master-clock cycles
  // ----------------------------------------------------------------
  localparam logic [10:0] SETTLE_CYC      = 11'd1280;
  localparam logic [10:0] SETTLE_CYC_SCL  = 11'd1536;
  localparam logic [19:0] WORD_CYC_BASE   = 20'd40960; // 120 Sps
  localparam logic [19:0] WORD_CYC_FAST   = 20'd1280;  // 3840 Sps
  typedef enum logic {ADCCFG_IDLE, ADCCFG_WAIT} adccfg_state_e;
endpackage

// file: adccfg_host.sv
// Purpose: host model driving the command port of the register bank
// Assumes: commands launched on falling edges, one word per command
// Notes:   released lines carry inverted values, so stale data never helps
`timescale 1ns/100ps
`default_nettype none
module adccfg_host (
  input  wire logic        clk_in,        // master clock
  input  wire logic        rd_valid_in,   // read word strobe
  input  wire logic [31:0] rd_data_in,    // read word
  output logic             cmd_valid_out, // command strobe
  output logic [7:0]       cmd_byte_out,  // command byte
  output logic [31:0]      cmd_data_out   // write word
);
  // ----------------------------------------------------------------
  // command launch
  // ----------------------------------------------------------------
  // idle port at time zero
  initial begin
    cmd_valid_out = 1'b0;
    cmd_byte_out  = 8'h00;
    cmd_data_out  = 32'h0000_0000;
  end

  // one full word per command, both setups of a register together
  task automatic send(input logic [7:0] cmd, input logic [31:0] data);
    @(negedge clk_in);
    cmd_valid_out = 1'b1;
    cmd_byte_out  = cmd;
    cmd_data_out  = data;
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    cmd_byte_out  = ~cmd;
    cmd_data_out  = ~data;
  endtask

  // read word arrives one cycle after the command edge
  task automatic read(input logic [7:0] cmd, output logic [31:0] word,
                      output logic ok);
    send(cmd, 32'h0000_0000);
    ok   = rd_valid_in;
    word = rd_data_in;
  endtask

  // write, then read in the very next cycle, no idle cycle between
  task automatic wr_then_rd(input logic [7:0] wcmd, input logic [31:0] data,
                            input logic [7:0] rcmd,
                            output logic [31:0] word);
    @(negedge clk_in);
    cmd_valid_out = 1'b1;
    cmd_byte_out  = wcmd;
    cmd_data_out  = data;
    @(negedge clk_in);
    cmd_byte_out  = rcmd;
    cmd_data_out  = ~data;
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    cmd_byte_out  = ~rcmd;
    word          = rd_data_in;
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Purpose: self-checking bench for the configuration and setup bank
// Assumes: outputs settle two cycles after a write command
// Notes:   latch pins are judged only after a command with a known source
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import adccfg_pkg::*;
  // ----------------------------------------------------------------
  // signals and shadow state
  // ----------------------------------------------------------------
  logic        clk_in = 1'b0;
  logic        reset_in, cmd_valid_in, conv_req_in, rd_valid_out;
  logic [7:0]  cmd_byte_in;
  logic [31:0] cmd_data_in, rd_data_out, cfg, w, d;
  logic [2:0]  setup_sel_in;
  logic        power_down_out, sleep_out, osc_run_out, sys_reset_out;
  logic        reset_done_out, input_short_out, guard_drive_out;
  logic        ref_range_out, latch_a0_out, latch_a1_out, polarity_out;
  logic        rate_valid_out, open_detect_out, settle_busy_out;
  logic        conv_go_out, rdone, ok, pins_known, busy_ok;
  logic [1:0]  channel_out, cal_index_out;
  logic [2:0]  gain_out;
  logic [19:0] word_period_out;
  logic [31:0] channel_setup [4];
  int          fail_count, samples_checked, rst_pulses, go_count;
  int          n, lat, g0;
  // bits the bank keeps; flag and reserved bits never stored
  localparam logic [31:0] stored_bits = 32'hEFD8_0000;

  always #20 clk_in = ~clk_in;

  adccfg_host host (.clk_in(clk_in), .rd_valid_in(rd_valid_out),
    .rd_data_in(rd_data_out), .cmd_valid_out(cmd_valid_in),
    .cmd_byte_out(cmd_byte_in), .cmd_data_out(cmd_data_in));

  adccfg_regs dut (.clk_in(clk_in), .reset_in(reset_in),
    .cmd_valid_in(cmd_valid_in), .cmd_byte_in(cmd_byte_in),
    .cmd_data_in(cmd_data_in), .setup_sel_in(setup_sel_in),
    .conv_req_in(conv_req_in), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .power_down_out(power_down_out),
    .sleep_out(sleep_out), .osc_run_out(osc_run_out),
    .sys_reset_out(sys_reset_out), .reset_done_out(reset_done_out),
    .input_short_out(input_short_out), .guard_drive_out(guard_drive_out),
    .ref_range_out(ref_range_out), .latch_a0_out(latch_a0_out),
    .latch_a1_out(latch_a1_out), .channel_out(channel_out),
    .gain_out(gain_out), .word_period_out(word_period_out),
    .rate_valid_out(rate_valid_out), .polarity_out(polarity_out),
    .open_detect_out(open_detect_out), .cal_index_out(cal_index_out),
    .settle_busy_out(settle_busy_out), .conv_go_out(conv_go_out));

  // pulse counters, so one-cycle strobes are never missed
  always @(negedge clk_in) begin
    if (!reset_in) begin
      rst_pulses += sys_reset_out;
      go_count   += conv_go_out;
    end
  end

  // ----------------------------------------------------------------
  // expectations and compares
  // ----------------------------------------------------------------
  // clocks per word; 40960 is 120 Sps at the nominal master clock
  function automatic logic [19:0] exp_period(input logic [3:0] c,
                                             input logic f);
    int p;
    if (c <= 4'h4) p = 40960 << c;
    else if (c >= 4'h8 && c <= 4'hC) p = 1280 << (c - 4'h8);
    else p = 0;
    if (f) p = p * 6 / 5; // rates times 5/6
    return p[19:0];
  endfunction

  task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_b(input logic got, input logic exp, input string what);
    cmp_w({31'h0, got}, {31'h0, exp}, what);
  endtask

  task automatic cmp_n(input int got, input int exp, input string what);
    cmp_w(got, exp, what);
  endtask

  task automatic wait_n(input int k);
    repeat (k) @(negedge clk_in);
  endtask

  // every decoded output against the shadow registers
  task automatic check_all();
    logic [15:0] s;
    logic        g;
    s = setup_sel_in[0] ? channel_setup[setup_sel_in[2:1]][15:0]
                        : channel_setup[setup_sel_in[2:1]][31:16];
    g = cfg[26];
    cmp_b(power_down_out, cfg[30], "pdw");
    cmp_b(sleep_out, cfg[31] & cfg[30], "sleep");
    cmp_b(osc_run_out, ~(cfg[31] & cfg[30]), "osc");
    cmp_b(input_short_out, cfg[27], "short");
    cmp_b(guard_drive_out, g, "guard");
    cmp_b(ref_range_out, cfg[25], "vref");
    if (pins_known) begin
      cmp_b(latch_a1_out, cfg[22] ? cfg[23] : s[4], "a1");
      cmp_b(latch_a0_out, ~g & (cfg[22] ? cfg[24] : s[5]),
            "a0");
    end
    cmp_w(32'(channel_out), 32'(s[15:14]), "chan");
    cmp_w(32'(gain_out), 32'(s[13:11]), "gain");
    cmp_w(32'(word_period_out), 32'(exp_period(s[10:7], cfg[19])),
          "period");
    cmp_b(rate_valid_out, exp_period(s[10:7], 1'b0) != 20'h0,
          "rv");
    cmp_b(polarity_out, s[6], "pol");
    cmp_b(open_detect_out, s[2], "ocd");
    cmp_w(32'(cal_index_out), 32'(cfg[20] ? s[1:0] : s[15:14]),
          "cal");
  endtask

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  task automatic wr_cfg(input logic [31:0] v);
    host.send(CMD_CFG_WR, v);
    cfg = v & stored_bits;
    pins_known = 1'b1;
    wait_n(2);
    check_all();
  endtask

  task automatic wr_csr(input logic [1:0] i, input logic [31:0] v);
    host.send(CMD_CSR_WR | {2'b00, i, 4'h0}, v);
    channel_setup[i] = v;
    pins_known = 1'b0; // old or new setup: left open, not judged
    wait_n(2);
    check_all();
  endtask

  task automatic rd_cfg();
    host.read(CMD_CFG_RD, w, ok);
    cmp_b(ok, 1'b1, "cfg strobe");
    cmp_w(w, cfg | {3'b000, rdone, 28'h0}, "cfg word");
    rdone = 1'b0;
    pins_known = 1'b1;
  endtask

  task automatic rd_csr(input logic [1:0] i);
    host.read(CMD_CSR_RD | {2'b00, i, 4'h0}, w, ok);
    cmp_b(ok, 1'b1, "csr strobe");
    cmp_w(w, channel_setup[i], "csr word");
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, fail_count);
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_in = 1'b1;
    setup_sel_in = 3'h0;
    conv_req_in = 1'b0;
    cfg = 32'h0;
    rdone = 1'b0;
    pins_known = 1'b1;
    foreach (channel_setup[i]) channel_setup[i] = 32'h0;
    w = $urandom(94);
    wait_n(3);
    reset_in = 1'b0;
    // outputs hold reset values until the first free edge
    wait_n(1);
    check_all();
    cmp_b(reset_done_out, 1'b0, "rv after reset");
    rd_cfg();
    end_test("reset");
    // all power modes first, then random legal words
    for (int k = 0; k < 16; k++) begin
      d = (k < 4) ? {k[1:0], 30'h0} : ($urandom & 32'hCFD8_0000);
      wr_cfg(d);
      rd_cfg();
    end
    wr_cfg(32'hDFFF_FFFF);
    rd_cfg();
    end_test("config");
    for (int i = 0; i < 4; i++) wr_csr(i[1:0], $urandom);
    for (int i = 0; i < 4; i++) rd_csr(i[1:0]);
    // write then read with no idle cycle between them
    d = $urandom;
    host.wr_then_rd(CMD_CSR_WR | 8'h20, d, CMD_CSR_RD | 8'h20, w);
    channel_setup[2] = d;
    cmp_w(w, d, "csr back to back");
    for (int p = 0; p < 2; p++) begin
      wr_cfg($urandom & (p == 1 ? 32'hCFD8_0000 : 32'hCF98_0000));
      for (int s = 0; s < 8; s++) begin
        setup_sel_in = s[2:0];
        wait_n(2);
        rd_cfg();
        wait_n(2);
        check_all();
      end
    end
    setup_sel_in = 3'h0;
    for (int k = 0; k < 32; k++) begin
      wr_cfg({12'h0, k[4], 19'h0});
      d = $urandom;
      d[26:23] = k[3:0];
      wr_csr(2'd0, d);
    end
    end_test("setups");
    // reset command alone, the only bit a host may set with it
    n = rst_pulses;
    host.send(CMD_CFG_WR, 32'h2000_0000);
    cfg = 32'h2000_0000;
    rdone = 1'b1;
    foreach (channel_setup[i]) channel_setup[i] = 32'h0;
    wait_n(3);
    cmp_n(rst_pulses - n, 1, "reset pulse");
    cmp_b(reset_done_out, 1'b1, "rv set");
    check_all();
    for (int i = 0; i < 4; i++) rd_csr(i[1:0]);
    rd_cfg();
    wait_n(1);
    cmp_b(reset_done_out, 1'b0, "rv clear");
    rd_cfg();
    wr_cfg(32'h0);
    end_test("system reset");
    // immediate start, then settle waits with a stray request inside
    for (int m = 0; m < 3; m++) begin
      wr_cfg({12'h0, m == 2, 19'h0});
      d = $urandom;
      d[19] = (m != 0);
      wr_csr(2'd0, d);
      // go shows the cycle after the edge that ends the wait
      lat = (m == 0) ? 1 : 1 + (m == 1 ? 1280 : 1536);
      g0 = go_count;
      busy_ok = 1'b1;
      conv_req_in = 1'b1;
      n = 0;
      do begin
        @(negedge clk_in);
        conv_req_in = (n == 99);
        n++;
        if (n < lat && settle_busy_out !== 1'b1) busy_ok = 1'b0;
      end while (conv_go_out !== 1'b1 && n < 2000);
      cmp_n(n, lat, "start delay");
      cmp_b(busy_ok, 1'b1, "settle busy");
      if (n >= 2000) report_and_stop();
      wait_n(3);
      cmp_n(go_count - g0, 1, "one start");
    end
    wr_cfg(32'h4000_0000);
    g0 = go_count;
    conv_req_in = 1'b1;
    wait_n(1);
    conv_req_in = 1'b0;
    wait_n(20);
    cmp_n(go_count - g0, 0, "start in power down");
    end_test("conversion");
    report_and_stop();
  end
endmodule
`default_nettype wire
